// *** inc/fps_defines.svh ***
/*
 * Constants of the fault supervisor: register offsets, field positions,
 * reset values, thresholds and timing figures.
 * Assumes inclusion by bare name from the design and the bench.
 */
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH
// =====================================================================
// Register offsets
`define FPS_A_CTRL 8'h00
`define FPS_A_TH 8'h04
`define FPS_A_RSP 8'h08
`define FPS_A_STAT 8'h0C
`define FPS_A_EVT 8'h10
`define FPS_A_MASK 8'h14
// =====================================================================
// Field positions and reset values
`define FPS_EN_BIT 0
`define FPS_CLR_BIT 1
`define FPS_OC_LSB 0
`define FPS_OV_LSB 4
`define FPS_UV_LSB 6
`define FPS_PGLO_BIT 8
`define FPS_PGHI_BIT 9
`define FPS_PGON_LSB 10
`define FPS_PGOFF_LSB 12
`define FPS_PGMODE_BIT 14
`define FPS_LATCH_LSB 0
`define FPS_TRKEN_BIT 5
`define FPS_STY_LSB 6
`define FPS_DLY_LSB 16
`define FPS_SLEW_LSB 22
`define FPS_TH_RST 32'h0000002A
`define FPS_RSP_RST 32'h00000140
// =====================================================================
// Shutdown styles
`define FPS_SEQ 2'h0
`define FPS_CRIT 2'h1
`define FPS_CAT 2'h2
// =====================================================================
// Thresholds, in percent, per mille, 0.1 degC and 2.5 mV steps
`define FPS_HUNDRED 12'h064
`define FPS_THOUSAND 12'h3E8
`define FPS_OC_BASE 12'h168
`define FPS_OC_STEP 12'h060
`define FPS_OC_MAX 4'hA
`define FPS_OV_BASE 12'h06E
`define FPS_OV_MAX 2'h2
`define FPS_UV_BASE 12'h04B
`define FPS_UV_MAX 2'h3
`define FPS_STEP10 12'h00A
`define FPS_STEP5 12'h005
`define FPS_PG_LO 12'h05A
`define FPS_PG_HI 12'h06E
`define FPS_T_HOT 12'h4B0
`define FPS_TW_CLR 12'h49F
`define FPS_OT_ON 12'h44C
`define FPS_TRK_LSB 13'h0064
`define FPS_I_RATED 12'h800
// =====================================================================
// Timing: milliseconds, microseconds per millisecond, clock in MHz
`define FPS_CLK_MHZ 100
`define FPS_MS_US 1000
`define FPS_RETRY_MS 130
`define FPS_PGD0 8'h00
`define FPS_PGD1 8'h0A
`define FPS_PGD2 8'h32
`define FPS_PGD3 8'h96
`endif

// *** inc/fps_pkg.sv ***
/*
 * Types of the fault supervisor: measurement and drive carriers, states.
 * Assumes nothing of its surroundings.
 */
package fps_pkg;
  // Measurements from the sensing chain, all on the controller clock.
  typedef struct packed {
    logic [11:0] vout;
    logic [11:0] vset;
    logic [11:0] vref;
    logic [11:0] iout;
    logic [11:0] temp;
  } fps_meas_type;
  // Switch drive permits and ramp request toward the power stage.
  typedef struct packed {
    logic hs_en;
    logic ls_en;
    logic ls_force;
    logic ramp_down;
  } fps_drive_type;
  typedef enum logic [1:0] {FPS_OFF, FPS_RUN, FPS_DLY, FPS_FLT} fps_state_type;
endpackage

// *** rtl/fps_top.sv ***
/*
 * Fault supervisor of a point-of-load converter with an APB register file.
 * Assumes measurements arrive synchronous to pclk and that a ramp engine
 * outside slews the output down when ramp_down is raised.
 */
// The APB register port and the register addresses were chosen for this implementation.
// Functional notes
// - Overcurrent threshold in 11 steps from 36 to 132 percent, 132 default.
// - Overvoltage threshold 110 to 130 percent in 10 percent steps, 130 default.
// - Undervoltage threshold 75 to 90 percent in 5 percent steps, 75 default.
// - Turn-off command within 6 us of a crossed threshold.
// - Sequenced style waits the turn-off delay then requests a slewed ramp.
// - Critical drops both drives; catastrophic drops high side, forces low side.
// - Overtemperature trips at 120 degC and restarts only at 110 degC.
// - Overtemperature hold clears once the warning is low and the temperature is at or below 110 degC.
// - Warning at 120 degC with 1.7 degC hysteresis, always reported.
// - Tracking check off by default, only during ramp up, 250 mV band.
// - Power good high inside window, 90 to 95 and 105 to 110 percent.
// - Power good rise delayed by 0, 10, 50 or 150 ms, 0 default.
// - Power good falls out of window, or after turn-off command with delay.
`timescale 1ns/100ps
`include "fps_defines.svh"
module fps_top import fps_pkg::*; #(
  parameter int MS_CYC = `FPS_MS_US * `FPS_CLK_MHZ,
  parameter int RETRY_MS = `FPS_RETRY_MS,
  parameter logic [11:0] I_RATED = `FPS_I_RATED
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fps_meas_type meas,
  input wire logic ramp_up,
  output fps_drive_type drive,
  output logic off_cmd,
  output logic [2:0] off_slew,
  output logic power_good_output,
  output logic irq
);
  // ===================================================================
  // Declarations
  logic en_r, latch_r, tw_r, tw_nxt, ot_hold_r, pg_r, irq_r, off_cmd_r;
  logic pready_r, pslverr_r, win, ov_c, uv_c, oc_c, ot_c, trk_c;
  logic [31:0] prdata_r, th_r, rsp_r, ms_pre_r;
  logic [5:0] ev_r, ev_nxt, mask_r;
  logic [4:0] trip, cause_r;
  logic [1:0] sty, style_r;
  logic [7:0] cnt_r, pg_cnt_r;
  logic ms_tick;
  logic [23:0] vo100, ov_lim, uv_lim, lo_lim, hi_lim, i_meas, i_lim;
  logic [11:0] oc_pm, ov_pct, uv_pct;
  logic [3:0] oc_idx;
  logic [12:0] diff, absd;
  fps_state_type state_r;
  fps_drive_type drive_r;
  wire setup = psel & ~penable;
  wire acc_wr = psel & penable & pready_r & pwrite;
  wire clr_cmd = acc_wr & (paddr == `FPS_A_CTRL) & pwdata[`FPS_CLR_BIT];
  wire [5:0] latch_en = {1'b0, rsp_r[`FPS_LATCH_LSB +: 5]};
  wire [5:0] ev_clr = (acc_wr && paddr == `FPS_A_EVT) ? pwdata[5:0] : 6'h00;

  // Product of two 12-bit quantities kept at 24 bits.
  function automatic logic [23:0] mul24(input logic [11:0] a, input logic [11:0] b);
    mul24 = 24'(a) * 24'(b);
  endfunction

  // Delay in milliseconds for a two-bit power-good delay choice.
  function automatic logic [7:0] pg_dly(input logic [1:0] s);
    case (s)
      2'h0: pg_dly = `FPS_PGD0;
      2'h1: pg_dly = `FPS_PGD1;
      2'h2: pg_dly = `FPS_PGD2;
      default: pg_dly = `FPS_PGD3;
    endcase
  endfunction

  // ===================================================================
  // APB slave: one wait-free access phase, unmapped offsets error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & (paddr > `FPS_A_MASK || paddr[1:0] != 2'h0);
      if (setup) begin
        case (paddr)
          `FPS_A_CTRL: prdata_r <= {31'h00000000, en_r};
          `FPS_A_TH: prdata_r <= th_r;
          `FPS_A_RSP: prdata_r <= rsp_r;
          `FPS_A_STAT: prdata_r <= {19'h00000, cause_r, 3'h0, latch_r, pg_r,
                                    off_cmd_r, state_r == FPS_RUN, tw_r};
          `FPS_A_EVT: prdata_r <= {26'h0000000, ev_r};
          `FPS_A_MASK: prdata_r <= {26'h0000000, mask_r};
          default: prdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  // Configuration registers written at the access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
      th_r <= `FPS_TH_RST;
      rsp_r <= `FPS_RSP_RST;
      mask_r <= 6'h00;
    end else if (acc_wr) begin
      case (paddr)
        `FPS_A_CTRL: en_r <= pwdata[`FPS_EN_BIT];
        `FPS_A_TH: th_r <= pwdata;
        `FPS_A_RSP: rsp_r <= pwdata;
        `FPS_A_MASK: mask_r <= pwdata[5:0];
        default: en_r <= en_r;
      endcase
    end
  end

  // ===================================================================
  // Millisecond prescaler shared by all delay counters.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_pre_r <= 32'h00000000;
    end else if (ms_pre_r >= 32'(MS_CYC - 1)) begin
      ms_pre_r <= 32'h00000000;
    end else begin
      ms_pre_r <= ms_pre_r + 32'h00000001;
    end
  end
  assign ms_tick = (ms_pre_r >= 32'(MS_CYC - 1));

  // ===================================================================
  // Threshold arithmetic and comparisons against the setpoint, reference, rated current and hot mark.
  always_comb begin
    oc_idx = (th_r[`FPS_OC_LSB +: 4] > `FPS_OC_MAX) ? `FPS_OC_MAX : th_r[`FPS_OC_LSB +: 4];
    oc_pm = `FPS_OC_BASE + 12'(`FPS_OC_STEP * {8'h00, oc_idx});
    ov_pct = `FPS_OV_BASE + ((th_r[`FPS_OV_LSB +: 2] >= `FPS_OV_MAX) ? 12'(`FPS_STEP10 * 2'h2)
             : 12'(`FPS_STEP10 * {10'h000, th_r[`FPS_OV_LSB +: 2]}));
    uv_pct = `FPS_UV_BASE + 12'(`FPS_STEP5 * {10'h000, th_r[`FPS_UV_LSB +: 2]});
    vo100 = mul24(meas.vout, `FPS_HUNDRED);
    ov_lim = mul24(meas.vset, ov_pct);
    uv_lim = mul24(meas.vset, uv_pct);
    lo_lim = mul24(meas.vset, `FPS_PG_LO + (th_r[`FPS_PGLO_BIT] ? `FPS_STEP5 : 12'h000));
    hi_lim = mul24(meas.vset, `FPS_PG_HI - (th_r[`FPS_PGHI_BIT] ? `FPS_STEP5 : 12'h000));
    i_meas = mul24(meas.iout, `FPS_THOUSAND);
    i_lim = mul24(I_RATED, oc_pm);
    diff = {1'b0, meas.vout} - {1'b0, meas.vref};
    absd = diff[12] ? 13'(~diff + 13'h0001) : diff;
    oc_c = i_meas >= i_lim;
    ov_c = vo100 > ov_lim;
    uv_c = vo100 < uv_lim;
    win = (vo100 >= lo_lim) && (vo100 <= hi_lim);
    trk_c = absd > `FPS_TRK_LSB;
    ot_c = $signed(meas.temp) >= $signed(`FPS_T_HOT);
  end

  // Trips are watched only while running; tracking only during ramp up.
  always_comb begin
    trip = 5'h00;
    if (state_r == FPS_RUN) begin
      trip = {rsp_r[`FPS_TRKEN_BIT] & ramp_up & trk_c, ot_c, uv_c & ~ramp_up, ov_c, oc_c};
    end
    sty = `FPS_SEQ;
    for (int i = 0; i < 5; i++) begin
      if (trip[i] && rsp_r[`FPS_STY_LSB + 2 * i +: 2] > sty) begin
        sty = rsp_r[`FPS_STY_LSB + 2 * i +: 2];
      end
    end
  end

  // ===================================================================
  // Temperature warning with hysteresis and overtemperature hold.
  always_comb begin
    tw_nxt = tw_r;
    if ($signed(meas.temp) >= $signed(`FPS_T_HOT)) begin
      tw_nxt = 1'b1;
    end else if ($signed(meas.temp) <= $signed(`FPS_TW_CLR)) begin
      tw_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tw_r <= 1'b0;
      ot_hold_r <= 1'b0;
    end else begin
      tw_r <= tw_nxt;
      if (trip[3]) begin
        ot_hold_r <= 1'b1;
      end else if (!tw_r && $signed(meas.temp) <= $signed(`FPS_OT_ON)) begin
        ot_hold_r <= 1'b0;
      end
    end
  end

  // ===================================================================
  // Supervisor state machine: run, sequenced delay, fault and retry.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= FPS_OFF;
      cnt_r <= 8'h00;
      cause_r <= 5'h00;
      style_r <= `FPS_SEQ;
      latch_r <= 1'b0;
    end else begin
      case (state_r)
        FPS_OFF: begin
          latch_r <= 1'b0;
          cnt_r <= 8'h00;
          if (en_r) begin
            state_r <= FPS_RUN;
          end
        end
        FPS_RUN: begin
          cnt_r <= 8'h00;
          if (!en_r) begin
            state_r <= FPS_OFF;
          end else if (|trip) begin
            cause_r <= trip;
            style_r <= sty;
            latch_r <= |(trip & latch_en[4:0]);
            state_r <= (sty == `FPS_SEQ && rsp_r[`FPS_DLY_LSB +: 6] != 6'h00)
                       ? FPS_DLY : FPS_FLT;
          end
        end
        FPS_DLY: begin
          if (!en_r) begin
            state_r <= FPS_OFF;
          end else if (cnt_r >= {2'h0, rsp_r[`FPS_DLY_LSB +: 6]}) begin
            cnt_r <= 8'h00;
            state_r <= FPS_FLT;
          end else if (ms_tick) begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        FPS_FLT: begin
          if (!en_r) begin
            state_r <= FPS_OFF;
          end else if (latch_r) begin
            if (clr_cmd && !ot_hold_r) begin
              latch_r <= 1'b0;
              state_r <= FPS_RUN;
            end
          end else if (cnt_r >= 8'(RETRY_MS)) begin
            cnt_r <= 8'h00;
            if (!ot_hold_r) begin
              state_r <= FPS_RUN;
            end
          end else if (ms_tick) begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        default: state_r <= FPS_OFF;
      endcase
    end
  end

  // Switch drives, turn-off command and slew code toward the power stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_r <= '0;
      off_cmd_r <= 1'b0;
    end else begin
      off_cmd_r <= (state_r == FPS_DLY) || (state_r == FPS_FLT);
      case (state_r)
        FPS_RUN, FPS_DLY: drive_r <= '{hs_en: 1'b1, ls_en: 1'b1, ls_force: 1'b0, ramp_down: 1'b0};
        FPS_FLT: begin
          case (style_r)
            `FPS_CRIT: drive_r <= '0;
            `FPS_CAT: drive_r <= '{hs_en: 1'b0, ls_en: 1'b1, ls_force: 1'b1,
                                  ramp_down: 1'b0};
            default: drive_r <= '{hs_en: 1'b1, ls_en: 1'b1, ls_force: 1'b0,
                                  ramp_down: 1'b1};
          endcase
        end
        default: drive_r <= '0;
      endcase
    end
  end

  // ===================================================================
  // Power good with selectable rise delay and reset-style fall.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_r <= 1'b0;
      pg_cnt_r <= 8'h00;
    end else if (!pg_r) begin
      if (!win) begin
        pg_cnt_r <= 8'h00;
      end else if (pg_cnt_r >= pg_dly(th_r[`FPS_PGON_LSB +: 2])) begin
        pg_r <= 1'b1;
        pg_cnt_r <= 8'h00;
      end else if (ms_tick) begin
        pg_cnt_r <= pg_cnt_r + 8'h01;
      end
    end else if (!th_r[`FPS_PGMODE_BIT]) begin
      pg_cnt_r <= 8'h00;
      if (!win) begin
        pg_r <= 1'b0;
      end
    end else if (!(off_cmd_r || state_r == FPS_OFF)) begin
      pg_cnt_r <= 8'h00;
    end else if (pg_cnt_r >= pg_dly(th_r[`FPS_PGOFF_LSB +: 2])) begin
      pg_r <= 1'b0;
      pg_cnt_r <= 8'h00;
    end else if (ms_tick) begin
      pg_cnt_r <= pg_cnt_r + 8'h01;
    end
  end

  // ===================================================================
  // Sticky events, write one to clear, a new event wins over the clear.
  assign ev_nxt = (ev_r & ~ev_clr) | {tw_nxt & ~tw_r, trip};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_r <= 6'h00;
      irq_r <= 1'b0;
    end else begin
      ev_r <= ev_nxt;
      irq_r <= |(ev_nxt & mask_r);
    end
  end

  // Outputs straight from their flip-flops.
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign drive = drive_r;
  assign off_cmd = off_cmd_r;
  assign power_good_output = pg_r;
  assign irq = irq_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_slew <= 3'h0;
    end else begin
      off_slew <= rsp_r[`FPS_SLEW_LSB +: 3];
    end
  end
endmodule // fps_top

// *** tb/fps_stage_model.sv ***
/*
 * Power stage and sensing model: the output follows its target while the high side runs without a ramp-down.
 * Assumes the bench sets the targets and the reference offset; the setpoint is fixed.
 */
`timescale 1ns/100ps
module fps_stage_model import fps_pkg::*; (
  input wire fps_drive_type drive,
  input wire logic [11:0] v_tgt,
  input wire logic [11:0] t_tgt,
  input wire logic [11:0] r_off,
  output fps_meas_type meas
);
  logic [11:0] vo;
  // ==========
  // The output collapses when the high side stops or a ramp-down is asked for.
  assign vo = (drive.hs_en && !drive.ramp_down) ? v_tgt : 12'h000;
  // One driver for the whole carrier: the reference leads the output by r_off.
  assign meas = '{vout: vo, vset: 12'h400, vref: vo + r_off, iout: 12'h100, temp: t_tgt};
endmodule // fps_stage_model

// *** tb/fps_top_asserts.sv ***
/*
 * Port checker of the fault supervisor: bus timing, trip response, drives, power good.
 * Assumes binding to fps_top and measurements scaled as the design expects.
 */
`timescale 1ns/100ps
module fps_asserts import fps_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire fps_meas_type meas,
  input wire logic ramp_up,
  input wire fps_drive_type drive,
  input wire logic off_cmd,
  input wire logic [2:0] off_slew,
  input wire logic power_good_output,
  input wire logic irq
);
  // ==========
  // Helper levels: a wide good window and the top trip marks.
  logic [19:0] vo;
  logic [19:0] vs;
  logic win_wide;
  logic ov_hi;
  logic ot_hi;
  assign vo = {8'h00, meas.vout};
  assign vs = {8'h00, meas.vset};
  assign win_wide = (vo * 20'h0000A >= vs * 20'h00009) && (vo * 20'h0000A <= vs * 20'h0000B);
  assign ov_hi = vo * 20'h00014 > vs * 20'h0001B;
  assign ot_hi = $signed(meas.temp) >= $signed(12'h4B0);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Bus handshake.
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("No ready after setup.");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("Ready held too long.");
  property p_err; pready |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0); endproperty
  a_err: assert property (p_err) else $error("Wrong error response.");
  property p_errz; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_errz: assert property (p_errz) else $error("Refused read not zero.");
  // ==========
  // Trip response, drive styles and power good.
  property p_ov; drive.hs_en && !off_cmd && ov_hi |-> ##[1:600] off_cmd; endproperty
  a_ov: assert property (p_ov) else $error("Late turn-off on overvoltage.");
  property p_ot; drive.hs_en && !off_cmd && ot_hi |-> ##[1:600] off_cmd; endproperty
  a_ot: assert property (p_ot) else $error("Late turn-off on heat.");
  property p_cat; drive.ls_force |-> drive.ls_en && !drive.hs_en && off_cmd; endproperty
  a_cat: assert property (p_cat) else $error("Bad forced low side.");
  property p_seq; drive.ramp_down |-> drive.hs_en && off_cmd; endproperty
  a_seq: assert property (p_seq) else $error("Bad ramp-down drive.");
  property p_pg; $rose(power_good_output) |-> $past(win_wide); endproperty
  a_pg: assert property (p_pg) else $error("Power good rose outside window.");
endmodule // fps_asserts

bind fps_top fps_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .meas(meas), .ramp_up(ramp_up), .drive(drive), .off_cmd(off_cmd), .off_slew(off_slew),
  .power_good_output(power_good_output), .irq(irq)
);

// *** tb/test_fault_protection_supervisor.sv ***
/*
 * Self-checking bench of the fault supervisor over APB with a stage model.
 * Assumes the checker is bound to fps_top; millisecond counts are shortened.
 */
`timescale 1ns/100ps
`include "fps_defines.svh"
module test_fault_protection_supervisor import fps_pkg::*; ();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ramp_up, err;
  logic off_cmd, power_good_output, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [11:0] v_tgt, t_tgt, r_off;
  logic [2:0] off_slew;
  fps_meas_type meas;
  fps_drive_type drive;
  int n_mismatch, n_checks, n;

  fps_top #(.MS_CYC(10), .RETRY_MS(3)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas(meas), .ramp_up(ramp_up), .drive(drive), .off_cmd(off_cmd), .off_slew(off_slew),
    .power_good_output(power_good_output), .irq(irq)
  );
  fps_stage_model u_stage (
    .drive(drive), .v_tgt(v_tgt), .t_tgt(t_tgt), .r_off(r_off), .meas(meas)
  );

  // ==========
  // Clock of 10 ns.
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  // ==========
  // Comparison and verdict.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One bus transfer; read data lands in q and the error response in err.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'h1 && i < 20);
    if (pready !== 1'h1) begin
      n_mismatch++;
      close_out;
    end else begin
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask

  // Waits, at most 400 cycles, for power good or the turn-off command to reach v.
  task automatic wt(input logic pg, input logic v);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (((pg ? power_good_output : off_cmd) !== v) && n < 400);
    if ((pg ? power_good_output : off_cmd) !== v) begin
      n_mismatch++;
      close_out;
    end
  endtask

  // Waits for the restart and for power good, then drops the ramp flag.
  task automatic restart;
    wt(1'h0, 1'h0);
    wt(1'h1, 1'h1);
    ramp_up <= 1'h0;
  endtask

  // ==========
  // Main sequence.
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ramp_up = 1'h0;
    v_tgt = 12'h400;
    t_tgt = 12'h0FA;
    r_off = 12'h000;
    n_mismatch = 0;
    n_checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    // Reset values, a read-only status word and an unmapped address.
    apb(1'h0, `FPS_A_TH, 32'h0);
    chk(q, 32'h0000002A);
    apb(1'h0, `FPS_A_RSP, 32'h0);
    chk(q, 32'h00000140);
    apb(1'h1, `FPS_A_STAT, 32'hFFFFFFFF);
    apb(1'h0, `FPS_A_STAT, 32'h0);
    chk(q, 32'h0);
    apb(1'h0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Start-up, then power good inside the window.
    ramp_up <= 1'h1;
    apb(1'h1, `FPS_A_CTRL, 32'h1);
    restart;
    apb(1'h0, `FPS_A_STAT, 32'h0);
    chk(q & 32'h1F, 32'h0A);
    // Overvoltage with the default critical style, interrupt masked, then raised.
    v_tgt <= 12'h570;
    repeat (4) @(posedge pclk);
    chk({27'h0, off_cmd, drive}, 32'h10);
    v_tgt <= 12'h400;
    ramp_up <= 1'h1;
    chk({30'h0, irq, power_good_output}, 32'h0);
    apb(1'h0, `FPS_A_EVT, 32'h0);
    chk(q, 32'h2);
    apb(1'h1, `FPS_A_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, `FPS_A_EVT, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    restart;
    // Latched catastrophic trip, then power good one delay step after the clear.
    apb(1'h1, `FPS_A_RSP, 32'h00000242);
    apb(1'h1, `FPS_A_TH, 32'h0000042A);
    v_tgt <= 12'h570;
    repeat (4) @(posedge pclk);
    chk({27'h0, off_cmd, drive}, 32'h16);
    v_tgt <= 12'h400;
    ramp_up <= 1'h1;
    repeat (100) @(posedge pclk);
    apb(1'h0, `FPS_A_STAT, 32'h0);
    chk(q & 32'h14, 32'h14);
    apb(1'h1, `FPS_A_CTRL, 32'h3);
    restart;
    chk({31'h0, n >= 85 && n <= 120}, 32'h1);
    // Overtemperature with sequenced style, warning hysteresis, restart at the low mark.
    apb(1'h1, `FPS_A_EVT, 32'h3F);
    t_tgt <= 12'h4B0;
    repeat (4) @(posedge pclk);
    chk({27'h0, off_cmd, drive}, 32'h1D);
    t_tgt <= 12'h4A6;
    repeat (60) @(posedge pclk);
    apb(1'h0, `FPS_A_STAT, 32'h0);
    chk(q & 32'h5, 32'h5);
    apb(1'h0, `FPS_A_EVT, 32'h0);
    chk(q & 32'h28, 32'h28);
    t_tgt <= 12'h44C;
    ramp_up <= 1'h1;
    restart;
    apb(1'h0, `FPS_A_STAT, 32'h0);
    chk(q & 32'h1, 32'h0);
    // Latched sequenced undervoltage at 90 percent, 2 ms delay, power good in reset mode.
    apb(1'h1, `FPS_A_RSP, 32'h01420004);
    apb(1'h1, `FPS_A_TH, 32'h000050EA);
    v_tgt <= 12'h3A0;
    repeat (4) @(posedge pclk);
    chk({28'h0, off_slew, off_cmd}, 32'hA);
    v_tgt <= 12'h380;
    repeat (4) @(posedge pclk);
    chk({26'h0, power_good_output, off_cmd, drive}, 32'h3C);
    repeat (25) @(posedge pclk);
    chk({26'h0, power_good_output, off_cmd, drive}, 32'h3D);
    // Power good falls 10 ms after the turn-off command, 27 cycles of which have passed.
    wt(1'h1, 1'h0);
    chk({31'h0, n >= 60 && n <= 80}, 32'h1);
    v_tgt <= 12'h400;
    ramp_up <= 1'h1;
    apb(1'h1, `FPS_A_CTRL, 32'h3);
    restart;
    // Latched critical tracking trip: only beyond 100 steps and only while ramping up.
    apb(1'h1, `FPS_A_RSP, 32'h00004030);
    ramp_up <= 1'h1;
    r_off <= 12'h064;
    repeat (4) @(posedge pclk);
    chk({31'h0, off_cmd}, 32'h0);
    r_off <= 12'h065;
    ramp_up <= 1'h0;
    repeat (4) @(posedge pclk);
    chk({31'h0, off_cmd}, 32'h0);
    ramp_up <= 1'h1;
    repeat (4) @(posedge pclk);
    chk({27'h0, off_cmd, drive}, 32'h10);
    apb(1'h0, `FPS_A_STAT, 32'h0);
    chk(q & 32'h1F14, 32'h1014);
    // Disabling leaves the latched fault for the off state.
    apb(1'h1, `FPS_A_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk({27'h0, off_cmd, drive}, 32'h0);
    close_out;
  end
endmodule // test_fault_protection_supervisor
